// ==== dv/pls_vco.sv ====
// oscillator and loop filter model that drives the two band inputs of the core
// assumes the core counts rising edges that are held at least two clk cycles
`timescale 1ns/1ps
module pls_vco import pls_pkg::*; (
  input wire logic clk,
  input wire pls_eo_t eo,
  output logic high_band_osc_input,
  output logic low_band_osc_input
);
  // ****************************************************
  // tuning and pulse generation
  // ****************************************************
  int half = 2; // cycles per half period, raise it to answer slowly
  int tune = 0;
  initial begin
    high_band_osc_input = 1'b0;
    low_band_osc_input = 1'b0;
  end
  // loop filter: integrate the driven error level; a floating pin holds the tune
  always @(posedge clk) begin
    if (eo.oe === 1'b1) begin
      tune <= (eo.level === 1'b1) ? tune + 1 : tune - 1;
    end
  end
  // send n rising edges on one band; the idle band rests low as if pulled down
  task automatic burst(input logic band_high, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (band_high) high_band_osc_input <= 1'b1;
      else low_band_osc_input <= 1'b1;
      repeat (half) @(posedge clk);
      high_band_osc_input <= 1'b0;
      low_band_osc_input <= 1'b0;
      repeat (half - 1) @(posedge clk);
    end
  endtask
endmodule

// ==== dv/tb_pls_synth.sv ====
// bench for the synthesizer core: registers, division ratios, reference rates, pin states
// assumes the oscillator model pls_vco and small reference counts for a short run
`timescale 1ns/1ps
module tb_pls_synth import pls_pkg::*; ();
  // ****************************************************
  // signals, instances and tasks
  // ****************************************************
  localparam int REF1 = 3000;
  localparam int REF125 = 2400;
  typedef struct {pls_sel_t sel; logic [15:0] d; logic b; int n;} pls_row_t;
  typedef struct {logic [3:0] c; int p;} pls_ref_t;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, awrdy, wrdy, bvalid, arrdy, rvalid, hi, lo;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp, resp;
  pls_eo_t eo;
  int num_errors, checked;
  time t0;
  pls_row_t rows[4] = '{'{PLS_SEL_LOW_DIRECT, 16'h0100, 1'b0, 16}, '{PLS_SEL_LOW_DIRECT, 16'h0C8F, 1'b0, 200},
    '{PLS_SEL_LOW_SWALLOW, 16'h0100, 1'b0, 256}, '{PLS_SEL_HIGH_SWALLOW, 16'h010F, 1'b1, 271}};
  pls_ref_t refs[3] = '{'{4'hD, 200}, '{4'hC, 400}, '{4'h2, REF125}};
  pls_synth #(.REF_DIV_1K(REF1), .REF_DIV_1K25(REF125)) pls_synth_i (.clk(clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .high_band_osc_input(hi), .low_band_osc_input(lo), .phase_error_output(eo));
  pls_vco pls_vco_i (.clk(clk), .eo(eo), .high_band_osc_input(hi), .low_band_osc_input(lo));
  // clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awrdy === 1'b1) awvalid <= 1'b0;
      if (wrdy === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arrdy === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // wait for the masked pin state, bounded by one slow reference period
  task automatic wt(input logic [1:0] v, input logic [1:0] m);
    int n;
    n = 0;
    while ((eo & m) !== v && n < 3200) begin
      @(posedge clk);
      n++;
    end
    chk(eo & m, v);
  endtask
  // feed edges after an up request until the divider fires, leaving it at reload
  task automatic align(input logic b, input int n);
    wt(2'b11, 2'b11);
    for (int k = 0; k <= n && eo.oe === 1'b1; k++) begin
      pls_vco_i.burst(b, 1);
      repeat (4) @(posedge clk);
    end
    chk(eo.oe, 1'b0);
  endtask
  // n-1 edges and foreign-band edges keep the up request, the nth ends it
  task automatic cnt(input logic b, input int n);
    wt(2'b11, 2'b11);
    pls_vco_i.burst(b, n - 1);
    pls_vco_i.burst(!b, 3);
    repeat (6) @(posedge clk);
    chk(eo, 2'b11); // foreign band ignored, pin high
    pls_vco_i.burst(b, 1);
    repeat (6) @(posedge clk);
    chk(eo.oe, 1'b0); // ratio reached, pin floats
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end
    else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****************************************************
  // test sequence
  // ****************************************************
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    num_errors = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    chk(eo.oe, 1'b0); // floats in reset
    resetn <= 1'b1;
    @(posedge clk);
    rd(PLS_ADDR_MODE);
    chk(got, 32'h0);
    rd(PLS_ADDR_DATA);
    chk(got, {16'h0, PLS_DATA_RST});
    $display("test reset done");
    // ratio table, all within the legal ranges
    foreach (rows[i]) begin // ratios kept legal
      // park the counters on the new ratio so the previous mode leaves no long count behind
      wr(PLS_ADDR_MODE, {24'h0, 4'h1, 2'b00, PLS_SEL_OFF});
      wr(PLS_ADDR_DATA, {16'h0, rows[i].d});
      wr(PLS_ADDR_MODE, {24'h0, 4'h1, 2'b00, rows[i].sel});
      rd(PLS_ADDR_DATA);
      chk(got, {16'h0, rows[i].d}); // ratio register
      align(rows[i].b, rows[i].n);
      cnt(rows[i].b, rows[i].n); // division per mode
      $display("test ratio %0d done", rows[i].n);
    end
    // new ratio written mid-cycle takes effect only at reload
    wt(2'b11, 2'b11);
    pls_vco_i.burst(1'b1, 5);
    wr(PLS_ADDR_DATA, 32'h0000_0140);
    pls_vco_i.burst(1'b1, 265);
    repeat (6) @(posedge clk);
    chk(eo, 2'b11); // running cycle kept
    pls_vco_i.burst(1'b1, 1);
    repeat (6) @(posedge clk);
    chk(eo.oe, 1'b0); // old ratio ends cycle
    cnt(1'b1, 320); // buffer loaded at reload
    $display("test reload done");
    // divider ahead of the reference drives the pin low
    pls_vco_i.burst(1'b1, 320);
    repeat (6) @(posedge clk);
    chk(eo, 2'b01); // down request, pin low
    wt(2'b00, 2'b01); // reference cancels
    $display("test down done");
    // unlock flags set by a long request, cleared by reading
    wt(2'b11, 2'b11);
    repeat (250) @(posedge clk);
    rd(PLS_ADDR_MODE);
    chk(got[3:2], 2'b11); // both flags set
    wr(PLS_ADDR_MODE, 32'h0000_0010);
    repeat (4) @(posedge clk);
    chk(eo.oe, 1'b0); // inputs off, pin floats
    rd(PLS_ADDR_MODE);
    rd(PLS_ADDR_MODE);
    chk(got, 32'h0000_0010); // read clears flags
    $display("test unlock done");
    // reference periods measured between up requests
    wr(PLS_ADDR_DATA, 32'h0000_0100);
    foreach (refs[i]) begin
      wr(PLS_ADDR_MODE, {24'h0, refs[i].c, 2'b00, PLS_SEL_LOW_DIRECT});
      align(1'b0, 16);
      wt(2'b11, 2'b11);
      t0 = $time;
      pls_vco_i.burst(1'b0, 16);
      repeat (6) @(posedge clk);
      wt(2'b11, 2'b11);
      chk(32'(($time - t0) / 100), 32'(refs[i].p)); // reference rate
    end
    wr(PLS_ADDR_MODE, {24'h0, 4'hE, 2'b00, PLS_SEL_LOW_DIRECT});
    repeat (3200) @(posedge clk);
    chk(eo.oe, 1'b0); // reserved code stops
    $display("test reference done");
    // unmapped address refused
    wr(8'h08, 32'h0000_00FF);
    chk(resp, PLS_RESP_SLVERR);
    rd(8'h08);
    chk(resp, PLS_RESP_SLVERR);
    chk(got, 32'h0);
    $display("test unmapped done");
    complete_run();
  end
  // watchdog well beyond the expected run
  initial begin
    #(100 * 95000);
    num_errors++;
    complete_run();
  end
endmodule

// ==== rtl/pls_pkg.sv ====
// package for the synthesizer divider and phase detector block
// assumes a 10 MHz system clock and an AXI4-Lite master with 32-bit data
package pls_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] PLS_ADDR_MODE = 8'h00;
  localparam logic [7:0] PLS_ADDR_DATA = 8'h04;
  localparam int PLS_MODE_SEL_LSB = 0;
  localparam int PLS_MODE_ULS_BIT = 2;
  localparam int PLS_MODE_ULF_BIT = 3;
  localparam int PLS_MODE_REF_LSB = 4;
  localparam logic [1:0] PLS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PLS_RESP_SLVERR = 2'h2;
  localparam logic [15:0] PLS_DATA_RST = 16'h0000;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int PLS_CLK_HZ = 10_000_000;
  localparam int PLS_UNLK_FAST_HZ = 1_000_000;
  localparam int PLS_UNLK_SLOW_HZ = 50_000;
  localparam int PLS_UNLK_FAST_CYC = PLS_CLK_HZ / PLS_UNLK_FAST_HZ;
  localparam int PLS_UNLK_SLOW_CYC = PLS_CLK_HZ / PLS_UNLK_SLOW_HZ;
  localparam int PLS_PRE_LOW = 16;
  localparam int PLS_PRE_HIGH = 17;

  // ****************************************************
  // input and division select
  // ****************************************************
  typedef enum logic [1:0] {
    PLS_SEL_OFF = 2'b00,
    PLS_SEL_HIGH_SWALLOW = 2'b01,
    PLS_SEL_LOW_SWALLOW = 2'b10,
    PLS_SEL_LOW_DIRECT = 2'b11
  } pls_sel_t;

  // error pin: level and drive enable
  typedef struct packed {
    logic level;
    logic oe;
  } pls_eo_t;

endpackage

// ==== rtl/pls_synth.sv ====
// synthesizer digital core: input select, programmable divider, reference, phase detector, unlock flags
// assumes oscillator inputs already synchronous to clk; error pin resolved outside from level and oe
// Function
// [R1] divide selected input, output phase error
// [R2] mode picks high or low band input
// [R3] mode picks direct or swallow division
// [R4] ratio written to register, passes buffer
// [R5] selectable reference from 1 to 50 kHz
// [R6] comparator flags which signal leads
// [R7] two readable sticky unlock flags
// [R8] error pin high, low, or floating
// [R9] prescaler 16/17, swallow, main, switch
// [R10] software keeps ratio within legal ranges
// [R11] select field codes off/high/low/direct
// [R12] swallow 4-bit, main 12-bit down counters
// [R13] direct uses upper 12, swallow all 16
// [R14] buffer loads counters only at reload; code also loads them every cycle while select is off
// [R15] divide by 17 until swallow expires
`timescale 1ns/1ps
module pls_synth import pls_pkg::*; #(
  parameter int CLK_HZ = PLS_CLK_HZ,
  parameter int REF_DIV_1K = PLS_CLK_HZ / 1000,
  parameter int REF_DIV_1K25 = PLS_CLK_HZ / 1250
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic high_band_osc_input,
  input wire logic low_band_osc_input,
  output pls_eo_t phase_error_output
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] ref_sel;
    pls_sel_t in_sel;
    logic unlock_flag_fast;
    logic unlock_flag_slow;
    logic [15:0] div_data;
    logic [15:0] div_buf;
    logic osc_prev;
    logic [4:0] pre_cnt;
    logic [3:0] swallow_stage;
    logic [11:0] main_count_stage;
    logic fn_pulse;
    logic [13:0] ref_cnt;
    logic ref_pulse;
    logic up_request;
    logic down_request;
    logic [3:0] fast_cnt;
    logic [7:0] slow_cnt;
    pls_eo_t eo;
  } pls_state_t;

  pls_state_t st_r;
  pls_state_t st_nxt;

  // reference divide count for a select code, zero means stopped
  function automatic logic [13:0] ref_div(input logic [3:0] sel);
    case (sel)
      4'h1: ref_div = 14'(REF_DIV_1K);
      4'h2: ref_div = 14'(REF_DIV_1K25);
      4'h3: ref_div = 14'(CLK_HZ / 2500);
      4'h4: ref_div = 14'(CLK_HZ / 3000);
      4'h5: ref_div = 14'(CLK_HZ / 5000);
      4'h6: ref_div = 14'(CLK_HZ / 6250);
      4'h7: ref_div = 14'(CLK_HZ / 9000);
      4'h8: ref_div = 14'(CLK_HZ / 10000);
      4'h9: ref_div = 14'(CLK_HZ / 12500);
      4'hA: ref_div = 14'(CLK_HZ / 18000);
      4'hB: ref_div = 14'(CLK_HZ / 20000);
      4'hC: ref_div = 14'(CLK_HZ / 25000);
      4'hD: ref_div = 14'(CLK_HZ / 50000);
      default: ref_div = 14'h0000;
    endcase
  endfunction

  // read value of a register, flags and select fields packed as on write
  function automatic logic [31:0] reg_read(input pls_state_t s, input logic [7:0] a);
    case (a)
      PLS_ADDR_MODE: reg_read = {24'h000000, s.ref_sel, s.unlock_flag_fast, s.unlock_flag_slow, s.in_sel};
      PLS_ADDR_DATA: reg_read = {16'h0000, s.div_data};
      default: reg_read = 32'h00000000;
    endcase
  endfunction

  // ****************************************************
  // next state
  // ****************************************************
  logic osc_sel;
  logic osc_edge;
  logic swallow_mode;
  logic pre_end;
  logic reload;
  logic [4:0] pre_mod;
  logic [13:0] ref_top;
  logic pd_on;
  logic do_write;
  logic rd_mode;
  logic set_fast;
  logic set_slow;
  logic err;

  always_comb begin
    st_nxt = st_r;
    // [R2] [R11] band input routing
    case (st_r.in_sel)
      PLS_SEL_HIGH_SWALLOW: osc_sel = high_band_osc_input;
      PLS_SEL_LOW_SWALLOW: osc_sel = low_band_osc_input;
      PLS_SEL_LOW_DIRECT: osc_sel = low_band_osc_input;
      default: osc_sel = 1'b0;
    endcase
    osc_edge = osc_sel & ~st_r.osc_prev;
    st_nxt.osc_prev = osc_sel;
    // [R3] [R9] division system switch
    swallow_mode = (st_r.in_sel != PLS_SEL_LOW_DIRECT);
    // [R15] modulus 17 while swallow counter runs
    pre_mod = (st_r.swallow_stage != 4'h0) ? 5'(PLS_PRE_HIGH) : 5'(PLS_PRE_LOW);
    pre_end = osc_edge && (!swallow_mode || (st_r.pre_cnt == pre_mod - 5'd1));
    reload = pre_end && (st_r.main_count_stage <= 12'h001);
    st_nxt.fn_pulse = 1'b0;
    if (st_r.in_sel == PLS_SEL_OFF) begin
      // [R11] inputs disabled, counters park loaded
      st_nxt.pre_cnt = 5'h00;
      st_nxt.main_count_stage = st_r.div_buf[15:4];
      st_nxt.swallow_stage = swallow_mode ? st_r.div_buf[3:0] : 4'h0;
    end else if (osc_edge) begin
      st_nxt.pre_cnt = pre_end ? 5'h00 : st_r.pre_cnt + 5'h01;
      if (pre_end) begin
        // [R12] down counters step once per prescaler cycle
        st_nxt.main_count_stage = st_r.main_count_stage - 12'h001;
        if (st_r.swallow_stage != 4'h0) begin
          st_nxt.swallow_stage = st_r.swallow_stage - 4'h1;
        end
      end
      if (reload) begin
        // [R14] [R13] [R10] buffered ratio enters here and while inputs are off
        st_nxt.main_count_stage = st_r.div_buf[15:4];
        st_nxt.swallow_stage = swallow_mode ? st_r.div_buf[3:0] : 4'h0;
        st_nxt.fn_pulse = 1'b1;
      end
    end
    // [R4] data buffer follows the data register
    st_nxt.div_buf = st_r.div_data;

    // [R5] reference generator
    ref_top = ref_div(st_r.ref_sel);
    pd_on = (ref_top != 14'h0000) && (st_r.in_sel != PLS_SEL_OFF);
    st_nxt.ref_pulse = 1'b0;
    if (ref_top == 14'h0000) begin
      st_nxt.ref_cnt = 14'h0000;
    end else if (st_r.ref_cnt >= ref_top - 14'h0001) begin
      st_nxt.ref_cnt = 14'h0000;
      st_nxt.ref_pulse = 1'b1;
    end else begin
      st_nxt.ref_cnt = st_r.ref_cnt + 14'h0001;
    end

    // [R6] [R1] three-state phase frequency detector
    if (!pd_on || (st_r.up_request && st_r.down_request)) begin
      st_nxt.up_request = 1'b0;
      st_nxt.down_request = 1'b0;
    end else begin
      st_nxt.up_request = st_r.up_request | st_r.ref_pulse;
      st_nxt.down_request = st_r.down_request | st_r.fn_pulse;
    end
    // [R8] charge pump drive
    st_nxt.eo.oe = st_r.up_request ^ st_r.down_request;
    st_nxt.eo.level = st_r.up_request & ~st_r.down_request;

    // [R7] unlock sampling at two rates
    err = st_r.up_request ^ st_r.down_request;
    set_fast = 1'b0;
    set_slow = 1'b0;
    if (st_r.fast_cnt >= 4'(PLS_UNLK_FAST_CYC - 1)) begin
      st_nxt.fast_cnt = 4'h0;
      set_fast = err;
    end else begin
      st_nxt.fast_cnt = st_r.fast_cnt + 4'h1;
    end
    if (st_r.slow_cnt >= 8'(PLS_UNLK_SLOW_CYC - 1)) begin
      st_nxt.slow_cnt = 8'h00;
      set_slow = err;
    end else begin
      st_nxt.slow_cnt = st_r.slow_cnt + 8'h01;
    end

    // bus write: address and data taken in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    do_write = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    if (do_write) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = PLS_RESP_OKAY;
      case (st_r.aw_addr)
        PLS_ADDR_MODE: begin
          if (st_r.wstrb[0]) begin
            st_nxt.in_sel = pls_sel_t'(st_r.wdata[PLS_MODE_SEL_LSB +: 2]);
            st_nxt.ref_sel = st_r.wdata[PLS_MODE_REF_LSB +: 4];
          end
        end
        PLS_ADDR_DATA: begin
          // [R4] software ratio into data register
          if (st_r.wstrb[0]) begin
            st_nxt.div_data[7:0] = st_r.wdata[7:0];
          end
          if (st_r.wstrb[1]) begin
            st_nxt.div_data[15:8] = st_r.wdata[15:8];
          end
        end
        default: st_nxt.bresp = PLS_RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;

    // bus read, mode register read clears unlock flags
    rd_mode = 1'b0;
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = reg_read(st_r, s_axi_araddr);
      st_nxt.rresp = ((s_axi_araddr == PLS_ADDR_MODE) || (s_axi_araddr == PLS_ADDR_DATA)) ?
        PLS_RESP_OKAY : PLS_RESP_SLVERR;
      rd_mode = (s_axi_araddr == PLS_ADDR_MODE);
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = !st_nxt.rvalid;
    // [R7] sticky flags, a new set beats the read clear
    st_nxt.unlock_flag_fast = set_fast | (st_r.unlock_flag_fast & ~rd_mode);
    st_nxt.unlock_flag_slow = set_slow | (st_r.unlock_flag_slow & ~rd_mode);
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.div_data <= PLS_DATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign phase_error_output = st_r.eo;

  // ****************************************************
  // checks
  // ****************************************************
  // [R8] pin floats with no request
  AST_EO_FLOAT: assert property (@(posedge clk) disable iff (!resetn) // [R8]
    (st_r.up_request == st_r.down_request) |=> !phase_error_output.oe)
    else $error("error pin driven with no single request");

  // [R8] up drives high next cycle
  AST_EO_UP_HIGH: assert property (@(posedge clk) disable iff (!resetn) // [R8]
    (st_r.up_request && !st_r.down_request) |=> (phase_error_output.oe && phase_error_output.level))
    else $error("up request not driven high");

  // [R6] reference pulse raises up request
  AST_REF_UP: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    (st_r.ref_pulse && pd_on && !st_r.up_request && !st_r.down_request) |=> st_r.up_request)
    else $error("reference edge lost by comparator");

  // [R15] swallow stage steps once per 17-edge cycle
  AST_SWALLOW_STEP: assert property (@(posedge clk) disable iff (!resetn) // [R15]
    (pre_end && !reload && swallow_mode && st_r.in_sel != PLS_SEL_OFF && st_r.swallow_stage != 4'h0
     && st_r.pre_cnt == 5'd16) |=> (st_r.swallow_stage == $past(st_r.swallow_stage) - 4'h1))
    else $error("swallow count did not step after 17 edges");

  // [R14] reload takes buffered value
  AST_RELOAD: assert property (@(posedge clk) disable iff (!resetn) // [R14]
    (reload && st_r.in_sel != PLS_SEL_OFF) |=> (st_r.fn_pulse && st_r.main_count_stage == $past(st_r.div_buf[15:4])))
    else $error("reload did not take buffered ratio");

  // [R13] direct mode ignores low four bits
  AST_DIRECT_NO_SWALLOW: assert property (@(posedge clk) disable iff (!resetn) // [R13]
    (st_r.in_sel == PLS_SEL_LOW_DIRECT && reload) |=> (st_r.swallow_stage == 4'h0))
    else $error("swallow loaded in direct mode");

  // [R11] disabled inputs give no divider output
  AST_OFF_QUIET: assert property (@(posedge clk) disable iff (!resetn) // [R11]
    (st_r.in_sel == PLS_SEL_OFF) |=> !st_r.fn_pulse)
    else $error("divider output while inputs disabled");

  // [R5] at code D no reference pulse within 8 cycles after one
  AST_REF_SPACING: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    (st_r.ref_pulse && st_r.ref_sel == 4'hD && $stable(st_r.ref_sel)) |=> !st_r.ref_pulse [*8])
    else $error("reference pulses too close");

  // [R7] flag held until read
  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!resetn) // [R7]
    (st_r.unlock_flag_fast && !(s_axi_arvalid && st_r.arready && s_axi_araddr == PLS_ADDR_MODE))
    |=> st_r.unlock_flag_fast)
    else $error("fast unlock flag dropped without read");

  // [R4] written ratio reaches buffer one cycle later
  AST_BUFFER: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    $changed(st_r.div_data) |=> (st_r.div_buf == $past(st_r.div_data)))
    else $error("data buffer did not follow register");

endmodule
